// File: hw/uart_rx_flags.sv
// Receive FIFO status flags with APB register access and interrupt
`timescale 1ns/1ps
`default_nettype none
module uart_rx_flags (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Power management
    input wire logic standby,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receiver core, same clock
    input wire logic rxWordValid,
    input wire logic [7:0] rxWordData,
    input wire logic rxWordParityErr,
    input wire logic rxStopEnd,
    input wire logic rxBusy,
    input wire logic etuTick,
    // Interrupt
    output logic irq
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    uart_rx_flags_pkg::apb_state_t state;
    logic clrAll;
    logic selStatus;
    logic selPort;
    logic selControl;
    logic selCount;
    logic selIntStatus;
    logic selIntMask;
    logic selNone;
    logic setupHit;
    logic done;
    logic rdDone;
    logic wrDone;
    logic [31:0] readMux;
    logic [1:0] trigSel;
    logic [4:0] threshold;
    logic [8:0] headWord;
    logic [4:0] fifoCount;
    logic fifoFull;
    logic fifoEmpty;
    logic pushNow;
    logic popNow;
    logic [4:0] cntAfter;
    logic parityErrFlag;
    logic rxFifoFullFlag;
    logic rxIdleTimeoutFlag;
    logic armFull;
    logic armIdle;
    logic fullSetEv;
    logic idleSetEv;
    logic timerExpired;
    logic fullClear;
    logic idleClear;
    logic [2:0] intStatus;
    logic [2:0] intMask;
    logic [2:0] intEvent;
    logic [2:0] intClear;
    logic [4:0] tickSince;

    function automatic logic [4:0] trigThreshold(input logic [1:0] sel);
        logic [4:0] t;
        t = uart_rx_flags_pkg::TRIG_COUNT_0;
        case (sel)
            2'h1: t = uart_rx_flags_pkg::TRIG_COUNT_1;
            2'h2: t = uart_rx_flags_pkg::TRIG_COUNT_2;
            2'h3: t = uart_rx_flags_pkg::TRIG_COUNT_3;
            default: t = uart_rx_flags_pkg::TRIG_COUNT_0;
        endcase
        return t;
    endfunction

    // Standby clears like reset but leaves the bus slave, the trigger select and the interrupt status, mask and irq alone
    assign clrAll = rst | standby;
    assign threshold = trigThreshold(trigSel);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    always_comb begin
        selStatus = 1'b0;
        selPort = 1'b0;
        selControl = 1'b0;
        selCount = 1'b0;
        selIntStatus = 1'b0;
        selIntMask = 1'b0;
        selNone = 1'b0;
        if (paddr == uart_rx_flags_pkg::ADDR_STATUS) begin
            selStatus = 1'b1;
        end else if (paddr == uart_rx_flags_pkg::ADDR_RX_PORT) begin
            selPort = 1'b1;
        end else if (paddr == uart_rx_flags_pkg::ADDR_CONTROL) begin
            selControl = 1'b1;
        end else if (paddr == uart_rx_flags_pkg::ADDR_COUNT) begin
            selCount = 1'b1;
        end else if (paddr == uart_rx_flags_pkg::ADDR_INT_STATUS) begin
            selIntStatus = 1'b1;
        end else if (paddr == uart_rx_flags_pkg::ADDR_INT_MASK) begin
            selIntMask = 1'b1;
        end else begin
            selNone = 1'b1;
        end
    end

    // ----------------------------------------
    // APB slave: one wait state, effects at completion
    // ----------------------------------------
    assign setupHit = psel & penable & (state == uart_rx_flags_pkg::ST_IDLE);
    assign done = psel & penable & pready;
    assign rdDone = done & ~pwrite & ~pslverr;
    assign wrDone = done & pwrite & ~pslverr;

    always_comb begin
        readMux = uart_rx_flags_pkg::RDATA_RESET;
        if (selStatus) begin
            readMux[uart_rx_flags_pkg::FLAG_PARITY_BIT] = parityErrFlag;
            readMux[uart_rx_flags_pkg::FLAG_FULL_BIT] = rxFifoFullFlag;
            readMux[uart_rx_flags_pkg::FLAG_IDLE_BIT] = rxIdleTimeoutFlag;
        end else if (selPort) begin
            readMux[7:0] = headWord[7:0];
        end else if (selControl) begin
            readMux[uart_rx_flags_pkg::TRIG_HI_BIT] = trigSel[1];
            readMux[uart_rx_flags_pkg::TRIG_LO_BIT] = trigSel[0];
        end else if (selCount) begin
            readMux[7:0] = {3'h0, fifoCount};
        end else if (selIntStatus) begin
            readMux[2:0] = intStatus;
        end else if (selIntMask) begin
            readMux[2:0] = intMask;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= uart_rx_flags_pkg::ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= uart_rx_flags_pkg::RDATA_RESET;
        end else begin
            case (state)
                uart_rx_flags_pkg::ST_IDLE: begin
                    if (setupHit) begin
                        state <= uart_rx_flags_pkg::ST_ACK;
                        pready <= 1'b1;
                        pslverr <= selNone;
                        prdata <= readMux;
                    end
                end
                uart_rx_flags_pkg::ST_ACK: begin
                    state <= uart_rx_flags_pkg::ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: begin
                    state <= uart_rx_flags_pkg::ST_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            trigSel <= uart_rx_flags_pkg::TRIG_SEL_RESET;
        end else if (wrDone && selControl) begin
            trigSel[1] <= pwdata[uart_rx_flags_pkg::TRIG_HI_BIT];
            trigSel[0] <= pwdata[uart_rx_flags_pkg::TRIG_LO_BIT];
        end
    end

    // ----------------------------------------
    // Receive FIFO and idle timer
    // ----------------------------------------
    assign pushNow = rxWordValid & ~fifoFull;
    assign popNow = rdDone & selPort & ~fifoEmpty;
    assign cntAfter = fifoCount + 5'(pushNow) - 5'(popNow);

    rx_fifo fifo (
        .core_clk(core_clk),
        .rst(clrAll),
        .pushValid(rxWordValid),
        .pushData({rxWordParityErr, rxWordData}),
        .popReq(popNow),
        .headData(headWord),
        .count(fifoCount),
        .full(fifoFull),
        .empty(fifoEmpty)
    );

    idle_timer timer (
        .core_clk(core_clk),
        .rst(clrAll),
        .restart(rxStopEnd),
        .hold(rxBusy),
        .tick(etuTick),
        .expired(timerExpired)
    );

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    assign fullSetEv = pushNow & (cntAfter > threshold);
    assign idleSetEv = timerExpired & (cntAfter != 5'h00)
        & (cntAfter < threshold);
    // A zero clears only after the flag was seen set
    assign fullClear = wrDone & selStatus & armFull
        & ~pwdata[uart_rx_flags_pkg::FLAG_FULL_BIT];
    assign idleClear = wrDone & selStatus & armIdle
        & ~pwdata[uart_rx_flags_pkg::FLAG_IDLE_BIT];

    always_ff @(posedge core_clk) begin
        if (clrAll) begin
            parityErrFlag <= uart_rx_flags_pkg::FLAG_RESET;
        end else if (popNow) begin
            parityErrFlag <= headWord[8];
        end
    end

    always_ff @(posedge core_clk) begin
        if (clrAll) begin
            rxFifoFullFlag <= uart_rx_flags_pkg::FLAG_RESET;
        end else if (fullSetEv) begin
            rxFifoFullFlag <= 1'b1;
        end else if (fullClear) begin
            rxFifoFullFlag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clrAll) begin
            rxIdleTimeoutFlag <= uart_rx_flags_pkg::FLAG_RESET;
        end else if (idleSetEv) begin
            rxIdleTimeoutFlag <= 1'b1;
        end else if (idleClear || rxBusy) begin
            rxIdleTimeoutFlag <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (clrAll) begin
            armFull <= 1'b0;
            armIdle <= 1'b0;
        end else if (rdDone && selStatus) begin
            armFull <= rxFifoFullFlag;
            armIdle <= rxIdleTimeoutFlag;
        end else if (wrDone && selStatus) begin
            armFull <= 1'b0;
            armIdle <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    assign intEvent = {popNow & headWord[8], fullSetEv, idleSetEv};
    assign intClear = (wrDone && selIntStatus) ? pwdata[2:0] : 3'h0;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            intStatus <= uart_rx_flags_pkg::INT_RESET;
        end else begin
            // New events win over a simultaneous clear
            intStatus <= (intStatus & ~intClear) | intEvent;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            intMask <= uart_rx_flags_pkg::INT_RESET;
        end else if (wrDone && selIntMask) begin
            intMask <= pwdata[2:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((intStatus & ~intClear) | intEvent) & intMask);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // Bit periods since the last stop bit, saturating
    always_ff @(posedge core_clk) begin
        if (rst || rxStopEnd) begin
            tickSince <= 5'h00;
        end else if (etuTick && tickSince != 5'h1f) begin
            tickSince <= tickSince + 5'h01;
        end
    end

    property p_parity_tracks;
        popNow && !standby |=> parityErrFlag == $past(headWord[8]);
    endproperty
    a_parity_tracks: assert property (p_parity_tracks)
        else $error("parity flag does not follow word read");

    property p_parity_clear;
        popNow && !headWord[8] && !standby |=> !parityErrFlag;
    endproperty
    a_parity_clear: assert property (p_parity_clear)
        else $error("parity flag stays set on clean word");

    property p_standby_clear;
        standby |=> !parityErrFlag && !rxFifoFullFlag && !rxIdleTimeoutFlag;
    endproperty
    a_standby_clear: assert property (p_standby_clear)
        else $error("flags survive standby");

    property p_full_set;
        pushNow && !standby && (fifoCount + 5'h01 - 5'(popNow)) > threshold
            |=> rxFifoFullFlag;
    endproperty
    a_full_set: assert property (p_full_set)
        else $error("full flag not set above trigger");

    property p_full_clear;
        done && pwrite && selStatus && armFull && !pwdata[1]
            && !fullSetEv && !standby |=> !rxFifoFullFlag;
    endproperty
    a_full_clear: assert property (p_full_clear)
        else $error("full flag not cleared by armed zero write");

    property p_write_one_keeps;
        done && pwrite && selStatus && pwdata[1] && rxFifoFullFlag
            && !standby |=> rxFifoFullFlag;
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps)
        else $error("written one cleared full flag");

    property p_fifo_bound;
        fifoCount <= uart_rx_flags_pkg::FIFO_FULL_COUNT;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound)
        else $error("fifo count above depth");

    property p_count_read;
        setupHit && !pwrite && selCount
            |=> prdata[7:0] == {3'h0, $past(fifoCount)} && pready;
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("count register shows wrong value");

    property p_idle_set;
        idleSetEv && !standby |=> rxIdleTimeoutFlag;
    endproperty
    a_idle_set: assert property (p_idle_set)
        else $error("idle flag not set after timeout");

    property p_idle_unarmed;
        rxIdleTimeoutFlag && !armIdle && !rxBusy && !standby
            |=> rxIdleTimeoutFlag;
    endproperty
    a_idle_unarmed: assert property (p_idle_unarmed)
        else $error("idle flag cleared without read as one");

    property p_timeout_length;
        timerExpired |-> tickSince == uart_rx_flags_pkg::IDLE_TICKS;
    endproperty
    a_timeout_length: assert property (p_timeout_length)
        else $error("timeout not fifteen bit periods");

    property p_restart;
        rxStopEnd |=> !timerExpired;
    endproperty
    a_restart: assert property (p_restart)
        else $error("timer fired right after stop bit");
endmodule
`default_nettype wire

// File: pkg/uart_rx_flags_pkg.sv
// Shared constants and types of the receive status flag block
package uart_rx_flags_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_RX_PORT = 8'h04;
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
    localparam logic [7:0] ADDR_INT_MASK = 8'h14;
    // ----------------------------------------
    // Field positions and widths
    // ----------------------------------------
    localparam int FLAG_IDLE_BIT = 0;
    localparam int FLAG_FULL_BIT = 1;
    localparam int FLAG_PARITY_BIT = 2;
    localparam int TRIG_LO_BIT = 6;
    localparam int TRIG_HI_BIT = 7;
    localparam int COUNT_FIELD_W = 8;
    localparam int INT_W = 3;
    localparam int DATA_W = 8;
    localparam int WORD_W = 9;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [1:0] TRIG_SEL_RESET = 2'h0;
    localparam logic [2:0] INT_RESET = 3'h0;
    localparam logic FLAG_RESET = 1'b0;
    // ----------------------------------------
    // Receive FIFO
    // ----------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_PTR_W = 4;
    localparam int FIFO_CNT_W = 5;
    localparam logic [4:0] FIFO_FULL_COUNT = 5'h10;
    localparam logic [4:0] TRIG_COUNT_0 = 5'h01;
    localparam logic [4:0] TRIG_COUNT_1 = 5'h04;
    localparam logic [4:0] TRIG_COUNT_2 = 5'h08;
    localparam logic [4:0] TRIG_COUNT_3 = 5'h0e;
    // ----------------------------------------
    // Idle timeout in bit periods
    // ----------------------------------------
    localparam int FRAME_BITS = 10;
    localparam int IDLE_ETU = FRAME_BITS * 3 / 2;
    localparam logic [3:0] IDLE_LAST = 4'(IDLE_ETU - 1);
    localparam logic [4:0] IDLE_TICKS = 5'(IDLE_ETU);
    // ----------------------------------------
    // Bus slave states
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK = 2'b10
    } apb_state_t;
endpackage

// File: hw/rx_fifo.sv
// Sixteen-word receive FIFO held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module rx_fifo (
    // Clock and clear
    input wire logic core_clk,
    input wire logic rst,
    // Fill side
    input wire logic pushValid,
    input wire logic [8:0] pushData,
    // Drain side
    input wire logic popReq,
    output logic [8:0] headData,
    // Fill state
    output logic [4:0] count,
    output logic full,
    output logic empty
);
    logic [8:0] mem [uart_rx_flags_pkg::FIFO_DEPTH];
    logic [3:0] wrPtr;
    logic [3:0] rdPtr;
    logic pushOk;
    logic popOk;

    assign full = (count == uart_rx_flags_pkg::FIFO_FULL_COUNT);
    assign empty = (count == 5'h00);
    // Words arriving while full are dropped
    assign pushOk = pushValid & ~full;
    assign popOk = popReq & ~empty;
    // An empty read shows a stale word
    assign headData = mem[rdPtr];

    always_ff @(posedge core_clk) begin
        if (pushOk) begin
            mem[wrPtr] <= pushData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wrPtr <= 4'h0;
            rdPtr <= 4'h0;
            count <= 5'h00;
        end else begin
            wrPtr <= wrPtr + 4'(pushOk);
            rdPtr <= rdPtr + 4'(popOk);
            count <= count + 5'(pushOk) - 5'(popOk);
        end
    end
endmodule
`default_nettype wire

// File: hw/idle_timer.sv
// Bit-period timer that fires after the idle gap following a stop bit
`timescale 1ns/1ps
`default_nettype none
module idle_timer (
    // Clock and clear
    input wire logic core_clk,
    input wire logic rst,
    // Timing events
    input wire logic restart,
    input wire logic hold,
    input wire logic tick,
    // Result
    output logic expired
);
    logic running;
    logic [3:0] cnt;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            running <= 1'b0;
            cnt <= 4'h0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (restart) begin
                running <= 1'b1;
                cnt <= 4'h0;
            end else if (hold) begin
                // A new frame cancels the pending gap
                running <= 1'b0;
            end else if (running && tick) begin
                if (cnt == uart_rx_flags_pkg::IDLE_LAST) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: test/remote_tx_model.sv
// Remote transmitter model driving the receiver-core side of the block
`timescale 1ns/1ps
`default_nettype none
module remote_tx_model #(
    parameter int ETU_CYC = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Receiver core side
    output logic etuTick,
    output logic rxWordValid,
    output logic [7:0] rxWordData,
    output logic rxWordParityErr,
    output logic rxStopEnd,
    output logic rxBusy
);
    // ----------------------------------------
    // Bit period and frames
    // ----------------------------------------
    int tickCnt;
    initial begin
        tickCnt = 0;
        etuTick = 1'b0;
        rxWordValid = 1'b0;
        rxWordData = 8'h00;
        rxWordParityErr = 1'b0;
        rxStopEnd = 1'b0;
        rxBusy = 1'b0;
    end
    // Baud tick runs free, one pulse per bit period
    always @(posedge core_clk) begin
        tickCnt <= (rst || tickCnt == ETU_CYC - 1) ? 0 : tickCnt + 1;
        etuTick <= !rst && tickCnt == ETU_CYC - 1;
    end
    // Ten-bit frame; data shows its inverse once no longer valid
    task automatic send(input logic [7:0] d, input logic pe);
        rxBusy <= 1'b1;
        repeat (9 * ETU_CYC) @(posedge core_clk);
        rxWordValid <= 1'b1;
        rxWordData <= d;
        rxWordParityErr <= pe;
        rxStopEnd <= 1'b1;
        rxBusy <= 1'b0;
        @(posedge core_clk);
        rxWordValid <= 1'b0;
        rxWordData <= ~d;
        rxWordParityErr <= ~pe;
        rxStopEnd <= 1'b0;
        @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the receive status flag block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int ETU = 8;
    logic core_clk, rst, standby, psel, penable, pwrite, pready, pslverr;
    logic irq, etuTick, rxWordValid, rxWordParityErr, rxStopEnd, rxBusy;
    logic errSeen;
    logic [7:0] paddr, rxWordData;
    logic [31:0] pwdata, prdata, rdv;
    int fail_count = 0;
    int cmp_count = 0;

    uart_rx_flags DUT (.core_clk(core_clk), .rst(rst), .standby(standby),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rxWordValid(rxWordValid),
        .rxWordData(rxWordData), .rxWordParityErr(rxWordParityErr),
        .rxStopEnd(rxStopEnd), .rxBusy(rxBusy), .etuTick(etuTick),
        .irq(irq));
    remote_tx_model #(.ETU_CYC(ETU)) tx (.core_clk(core_clk), .rst(rst),
        .etuTick(etuTick), .rxWordValid(rxWordValid),
        .rxWordData(rxWordData), .rxWordParityErr(rxWordParityErr),
        .rxStopEnd(rxStopEnd), .rxBusy(rxBusy));

    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Request stands until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n == 50) fail_count++;
        rdv = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdv, exp);
    endtask
    task automatic end_of_test();
        $display("Compares: %0d, mismatches: %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (10000) @(posedge core_clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        rst = 1'b1;
        standby = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(uart_rx_flags_pkg::ADDR_STATUS, 32'h0);
        rd(uart_rx_flags_pkg::ADDR_COUNT, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(uart_rx_flags_pkg::ADDR_CONTROL, 32'(i) << 6);
            rd(uart_rx_flags_pkg::ADDR_CONTROL, 32'(i) << 6);
        end
        // Threshold 4, only the idle event reaches the interrupt
        wr(uart_rx_flags_pkg::ADDR_CONTROL, 32'h40);
        wr(uart_rx_flags_pkg::ADDR_INT_MASK, 32'h1);
        rd(uart_rx_flags_pkg::ADDR_INT_MASK, 32'h1);
        for (int i = 0; i < 5; i++) begin
            tx.send(8'(17 * (i + 1)), i == 1);
            rd(uart_rx_flags_pkg::ADDR_STATUS, (i == 4) ? 32'h2 : 32'h0);
        end
        rd(uart_rx_flags_pkg::ADDR_COUNT, 32'h5);
        chk(32'(irq), 32'h0);
        wr(uart_rx_flags_pkg::ADDR_STATUS, 32'h7);
        wr(uart_rx_flags_pkg::ADDR_STATUS, 32'h0);
        rd(uart_rx_flags_pkg::ADDR_STATUS, 32'h2);
        // Three reads only, below the trigger of four
        for (int i = 0; i < 3; i++) begin
            rd(uart_rx_flags_pkg::ADDR_RX_PORT, 32'(17 * (i + 1)));
            rd(uart_rx_flags_pkg::ADDR_STATUS, (i == 1) ? 32'h6 : 32'h2);
        end
        // Full event and popped parity error are both pending
        rd(uart_rx_flags_pkg::ADDR_INT_STATUS, 32'h6);
        wr(uart_rx_flags_pkg::ADDR_STATUS, 32'h0);
        rd(uart_rx_flags_pkg::ADDR_STATUS, 32'h0);
        repeat (20 * ETU) @(posedge core_clk);
        rd(uart_rx_flags_pkg::ADDR_STATUS, 32'h1);
        chk(32'(irq), 32'h1);
        wr(uart_rx_flags_pkg::ADDR_STATUS, 32'h0);
        rd(uart_rx_flags_pkg::ADDR_STATUS, 32'h0);
        wr(uart_rx_flags_pkg::ADDR_INT_STATUS, 32'h7);
        rd(uart_rx_flags_pkg::ADDR_INT_STATUS, 32'h0);
        // Timeout measured from the stop bit of a fresh word
        tx.send(8'h5a, 1'b0);
        repeat (12 * ETU) @(posedge core_clk);
        rd(uart_rx_flags_pkg::ADDR_STATUS, 32'h0);
        chk(32'(irq), 32'h0);
        repeat (10 * ETU) @(posedge core_clk);
        rd(uart_rx_flags_pkg::ADDR_STATUS, 32'h1);
        rd(uart_rx_flags_pkg::ADDR_INT_STATUS, 32'h1);
        chk(32'(irq), 32'h1);
        standby <= 1'b1;
        @(posedge core_clk);
        standby <= 1'b0;
        @(posedge core_clk);
        rd(uart_rx_flags_pkg::ADDR_STATUS, 32'h0);
        rd(uart_rx_flags_pkg::ADDR_COUNT, 32'h0);
        // Seventeenth word finds no room
        for (int i = 0; i < 17; i++) begin
            tx.send(8'(i), 1'b0);
        end
        rd(uart_rx_flags_pkg::ADDR_COUNT, 32'h10);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(errSeen), 32'h1);
        for (int i = 0; i < 16; i++) begin
            rd(uart_rx_flags_pkg::ADDR_RX_PORT, 32'(i));
        end
        apb(1'b0, uart_rx_flags_pkg::ADDR_RX_PORT, 32'h0);
        rd(uart_rx_flags_pkg::ADDR_COUNT, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
